// ---- include/sma_pkg.sv ----
// Constants and command codes shared by both ends of the supply monitor link.
// Assumes a 100 MHz system clock on both ends.
package sma_pkg;
  // Converter
  localparam int ADC_BITS = 11;
  localparam int NUM_CH = 3;
  localparam logic [1:0] CH_TEMP = 2'h0;
  localparam logic [1:0] CH_SUPPLY = 2'h1;
  localparam logic [1:0] CH_GPIO = 2'h2;
  localparam logic [1:0] CH_LAST = 2'h2;
  localparam logic [NUM_CH-1:0] CH_SUPPLY_MASK = 3'h2;
  localparam int MV_W = 12;
  localparam logic [MV_W-1:0] SUPPLY_FS_MV = 12'he10;  // 3600 mV full scale
  // Threshold: code 0 is 1.5 V, code 31 is 3.05 V
  localparam int THR_W = 5;
  localparam logic [MV_W-1:0] THR_MIN_MV = 12'h5dc;    // 1500 mV
  localparam logic [MV_W-1:0] THR_STEP_MV = 12'h032;   // 50 mV
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int CONV_RATE_MAX_HZ = 2440;
  localparam int CONV_MIN_CYCLES = (CLK_HZ + CONV_RATE_MAX_HZ - 1) / CONV_RATE_MAX_HZ;
  localparam int WAKE_TICK_NS = 122070;                // 4 / 32.768 kHz
  localparam int WAKE_TICK_DEF_CYCLES = WAKE_TICK_NS / CLK_NS;
  localparam int POR_DEF_CYCLES = 16;
  localparam int CLKOUT_DEF_DIV = 4;
  localparam int HOST_HALF_DEF = 8;
  // Serial framing
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [7:0] CMD_SET_PROP = 8'h11;
  localparam logic [7:0] CMD_READ_CONVERTER = 8'h14;
  localparam logic [7:0] CMD_GET_STATUS = 8'h20;
  localparam logic [7:0] CMD_READ_REPLY = 8'h44;
  localparam logic [7:0] REPLY_READY = 8'hff;
  localparam logic [7:0] REPLY_BUSY = 8'h00;
  // Properties and fields
  localparam logic [7:0] PROP_WAKE_CFG = 8'h00;
  localparam logic [7:0] PROP_SUPPLY_THR = 8'h01;
  localparam logic [7:0] PROP_IRQ_EN = 8'h02;
  localparam logic [7:0] PROP_GPIO0 = 8'h03;
  localparam logic [7:0] PROP_GPIO1 = 8'h04;
  localparam logic [7:0] PROP_WAKE_PERIOD = 8'h05;
  localparam int CFG_WAKE_EN_BIT = 0;
  localparam int CFG_DET_EN_BIT = 1;
  localparam int ST_WAKE_BIT = 0;
  localparam int ST_LOW_BIT = 1;
  // General pin functions
  localparam int NUM_GPIO = 2;
  localparam int GPF_W = 3;
  localparam logic [GPF_W-1:0] GPF_OFF = 3'h0;
  localparam logic [GPF_W-1:0] GPF_CLK = 3'h1;
  localparam logic [GPF_W-1:0] GPF_BUF = 3'h2;
  localparam logic [GPF_W-1:0] GPF_POR = 3'h3;
  localparam logic [GPF_W-1:0] GPF_WAKE = 3'h4;
  localparam logic [GPF_W-1:0] GPF_LOW = 3'h5;
endpackage

// ---- include/sma_link_if.sv ----
// Four-line serial link plus interrupt and shutdown between host and device.
// Assumes the bench resolves the data-out wire from its enable.
`timescale 1ns/1ps
`default_nettype none
interface sma_link_if;
  logic sclk;
  logic serial_select_n;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic irq_out_n;
  logic shutdown_in;

  // Device end
  modport dev (
    input  sclk,
    input  serial_select_n,
    input  sdi,
    input  shutdown_in,
    output sdo,
    output sdo_oe_n,
    output irq_out_n
  );

  // Host end
  modport host (
    output sclk,
    output serial_select_n,
    output sdi,
    output shutdown_in,
    input  sdo,
    input  sdo_oe_n,
    input  irq_out_n
  );
endinterface
`default_nettype wire

// ---- verilog/sma_dev.sv ----
// Device end: serial slave, property store, SAR converter control,
// wake timer, low-supply detector and general pin functions.
// Assumes link pins and comparator are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sma_dev
  import sma_pkg::*;
#(
  parameter int CONV_CYCLES      = CONV_MIN_CYCLES,
  parameter int WAKE_TICK_CYCLES = WAKE_TICK_DEF_CYCLES,
  parameter int POR_CYCLES       = POR_DEF_CYCLES,
  parameter int CLKOUT_DIV       = CLKOUT_DEF_DIV
) (
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  sma_link_if.dev                  lnk,
  output wire logic [ADC_BITS-1:0] sar_trial,
  output wire logic [1:0]          sar_chan,
  input  wire logic                sar_cmp,
  output wire logic [NUM_GPIO-1:0] gpio_out,
  output wire logic [NUM_GPIO-1:0] gpio_oe_n
);
  // Round up so a conversion never beats the fastest allowed rate
  localparam int BIT_CYCLES = (CONV_CYCLES + ADC_BITS - 1) / ADC_BITS;

  typedef enum logic {SMA_ADC_IDLE, SMA_ADC_CONV} sma_adc_st_t;

  typedef struct packed {
    logic [6:0]            rx;
    logic [2:0]            bitc;
    logic [2:0]            byte_i;
    logic [7:0]            cmd;
    logic [7:0]            arg;
    logic [7:0]            tx;
    logic                  sdo;
    logic                  sdo_oe_n;
    logic                  irq_n;
    logic                  wake_en;
    logic                  det_en;
    logic [THR_W-1:0]      thr;
    logic [1:0]            irq_en;
    logic [GPF_W-1:0]      gpf0;
    logic [GPF_W-1:0]      gpf1;
    logic [7:0]            period;
    logic [1:0]            status;
    logic [NUM_CH-1:0]     req_mask;
    logic [NUM_CH-1:0]     sel_mask;
    logic                  conv_req;
  } sma_spi_t;

  typedef struct packed {
    sma_adc_st_t                       st;
    logic [NUM_CH-1:0]                 pend;
    logic [1:0]                        ch;
    logic [3:0]                        bitp;
    logic [ADC_BITS-1:0]               trial;
    logic [31:0]                       cnt;
    logic                              det_chk;
    logic                              low_evt;
    logic [NUM_CH-1:0][ADC_BITS-1:0]   res;
  } sma_adc_t;

  typedef struct packed {
    logic [31:0]           pre;
    logic [7:0]            per;
    logic                  wake_evt;
    logic                  det_req;
    logic [15:0]           por_cnt;
    logic [15:0]           div;
    logic                  clk_o;
    logic [NUM_GPIO-1:0]   gout;
    logic [NUM_GPIO-1:0]   goe_n;
  } sma_tmr_t;

  localparam sma_spi_t SPI_RST = '{sdo_oe_n: 1'b1, irq_n: 1'b1, default: '0};
  localparam sma_adc_t ADC_RST = '{st: SMA_ADC_IDLE, default: '0};
  localparam sma_tmr_t TMR_RST = '{goe_n: '1, default: '0};

  sma_spi_t            spi_r;
  sma_spi_t            spi_nxt;
  sma_adc_t            adc_r;
  sma_adc_t            adc_nxt;
  sma_tmr_t            tmr_r;
  sma_tmr_t            tmr_nxt;
  logic [2:0]          sclk_q;
  logic [1:0]          sel_q;
  logic [1:0]          sdi_q;
  logic [1:0]          shd_q;
  logic [1:0]          cmp_q;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                sel_act;
  logic                shd;
  logic                adc_busy;
  logic [MV_W-1:0]     thr_mv;

  // Two-stage synchronisers; third sclk stage only for edges
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= '0;
      sel_q  <= '1;
      sdi_q  <= '0;
      shd_q  <= '0;
      cmp_q  <= '0;
    end else begin
      sclk_q <= {sclk_q[1:0], lnk.sclk};
      sel_q  <= {sel_q[0], lnk.serial_select_n};
      sdi_q  <= {sdi_q[0], lnk.sdi};
      shd_q  <= {shd_q[0], lnk.shutdown_in};
      cmp_q  <= {cmp_q[0], sar_cmp};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign sel_act   = ~sel_q[1];
  assign shd       = shd_q[1];
  assign adc_busy  = (adc_r.st != SMA_ADC_IDLE) | (|adc_r.pend);
  assign thr_mv    = THR_MIN_MV + MV_W'(spi_r.thr) * THR_STEP_MV;

  // Serial slave, properties and status flags
  always_comb begin
    sma_spi_t   s;
    logic [7:0] b;
    logic [7:0] c;
    logic [2:0] ri;
    s  = spi_r;
    b  = {spi_r.rx, sdi_q[1]};
    c  = (spi_r.byte_i == 3'h0) ? b : spi_r.cmd;
    ri = spi_r.byte_i - 3'h1;
    s.conv_req = 1'b0;
    s.irq_n = ~|(spi_r.status & spi_r.irq_en);
    if (!sel_act) begin
      s.bitc     = '0;
      s.byte_i   = '0;
      s.sdo      = 1'b0;
      s.sdo_oe_n = 1'b1;
    end else begin
      s.sdo_oe_n = 1'b0;
      if (sclk_fall) begin
        s.sdo = spi_r.tx[7];
        s.tx  = {spi_r.tx[6:0], 1'b0};
      end
      if (sclk_rise) begin
        s.rx   = b[6:0];
        s.bitc = spi_r.bitc + 3'h1;
        if (spi_r.bitc == BIT_LAST) begin
          if (spi_r.byte_i != BYTE_LAST) begin
            s.byte_i = spi_r.byte_i + 3'h1;
          end
          s.tx = 8'h00;
          if (spi_r.byte_i == 3'h0) begin
            s.cmd = b;
          end
          case (c)
            CMD_SET_PROP: begin
              if (spi_r.byte_i == 3'h1) begin
                s.arg = b;
              end else if (spi_r.byte_i == 3'h2) begin
                case (spi_r.arg)
                  PROP_WAKE_CFG: begin
                    s.wake_en = b[CFG_WAKE_EN_BIT];
                    s.det_en  = b[CFG_DET_EN_BIT];
                  end
                  PROP_SUPPLY_THR:  s.thr    = b[THR_W-1:0];
                  PROP_IRQ_EN:      s.irq_en = b[1:0];
                  PROP_GPIO0:       s.gpf0   = b[GPF_W-1:0];
                  PROP_GPIO1:       s.gpf1   = b[GPF_W-1:0];
                  PROP_WAKE_PERIOD: s.period = b;
                  default: ;
                endcase
              end
            end
            CMD_READ_CONVERTER: begin
              if (spi_r.byte_i == 3'h1) begin
                s.req_mask = b[NUM_CH-1:0];
                s.sel_mask = b[NUM_CH-1:0];
                s.conv_req = 1'b1;
              end
            end
            CMD_GET_STATUS: begin
              if (spi_r.byte_i == 3'h0) begin
                s.tx     = {6'h00, spi_r.status};
                s.status = '0;
              end
            end
            CMD_READ_REPLY: begin
              if (spi_r.byte_i == 3'h0) begin
                s.tx = adc_busy ? REPLY_BUSY : REPLY_READY;
              end else if (ri[2:1] <= CH_LAST && spi_r.sel_mask[ri[2:1]]) begin
                s.tx = ri[0] ? adc_r.res[ri[2:1]][7:0] : 8'(adc_r.res[ri[2:1]] >> BYTE_W);
              end
            end
            default: ;
          endcase
        end
      end
    end
    // Event set after the read clear so a coincident event survives
    s.status[ST_WAKE_BIT] = s.status[ST_WAKE_BIT] | tmr_r.wake_evt;
    s.status[ST_LOW_BIT]  = s.status[ST_LOW_BIT] | adc_r.low_evt;
    if (shd) begin
      s = SPI_RST;
    end
    spi_nxt = s;
  end

  // Successive approximation sequencer, lowest channel first
  always_comb begin
    sma_adc_t                a;
    logic [ADC_BITS-1:0]     t;
    logic [ADC_BITS+11:0]    prod;
    a    = adc_r;
    t    = adc_r.trial;
    prod = '0;
    a.low_evt = 1'b0;
    unique case (adc_r.st)
      SMA_ADC_IDLE: begin
        if (|adc_r.pend) begin
          for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (adc_r.pend[i]) begin
              a.ch = 2'(i);
            end
          end
          a.st    = SMA_ADC_CONV;
          a.bitp  = 4'(ADC_BITS - 1);
          a.trial = {1'b1, {(ADC_BITS-1){1'b0}}};
          a.cnt   = '0;
        end
      end
      SMA_ADC_CONV: begin
        if (adc_r.cnt == 32'(BIT_CYCLES - 1)) begin
          a.cnt = '0;
          if (!cmp_q[1]) begin
            t[adc_r.bitp] = 1'b0;
          end
          if (adc_r.bitp == 4'h0) begin
            a.res[adc_r.ch]  = t;
            a.pend[adc_r.ch] = 1'b0;
            a.st = SMA_ADC_IDLE;
            if (adc_r.ch == CH_SUPPLY && adc_r.det_chk) begin
              a.det_chk = 1'b0;
              prod = (ADC_BITS + 12)'(t) * (ADC_BITS + 12)'(SUPPLY_FS_MV);
              a.low_evt = prod[ADC_BITS +: MV_W] < thr_mv;
            end
          end else begin
            t[adc_r.bitp - 4'h1] = 1'b1;
            a.bitp = adc_r.bitp - 4'h1;
          end
          a.trial = t;
        end else begin
          a.cnt = adc_r.cnt + 32'h1;
        end
      end
    endcase
    // Requests merged last so a finish never swallows a new one
    a.pend = a.pend | (spi_r.conv_req ? spi_r.req_mask : '0)
                    | (tmr_r.det_req ? CH_SUPPLY_MASK : '0);
    a.det_chk = a.det_chk | tmr_r.det_req;
    if (shd) begin
      a = ADC_RST;
    end
    adc_nxt = a;
  end

  // Wake timer, power-on flag, clock divider and general pins
  always_comb begin
    sma_tmr_t         m;
    logic [GPF_W-1:0] f;
    m = tmr_r;
    f = GPF_OFF;
    m.wake_evt = 1'b0;
    m.det_req  = 1'b0;
    if (spi_r.wake_en) begin
      if (tmr_r.pre == 32'(WAKE_TICK_CYCLES - 1)) begin
        m.pre = '0;
        if ({1'b0, tmr_r.per} + 9'h001 >= {1'b0, spi_r.period}) begin
          m.per      = '0;
          m.wake_evt = 1'b1;
          m.det_req  = spi_r.det_en;
        end else begin
          m.per = tmr_r.per + 8'h01;
        end
      end else begin
        m.pre = tmr_r.pre + 32'h1;
      end
    end else begin
      m.pre = '0;
      m.per = '0;
    end
    if (tmr_r.por_cnt != 16'(POR_CYCLES)) begin
      m.por_cnt = tmr_r.por_cnt + 16'h0001;
    end
    if (tmr_r.div == 16'(CLKOUT_DIV - 1)) begin
      m.div   = '0;
      m.clk_o = ~tmr_r.clk_o;
    end else begin
      m.div = tmr_r.div + 16'h0001;
    end
    for (int i = 0; i < NUM_GPIO; i++) begin
      f = (i == 0) ? spi_r.gpf0 : spi_r.gpf1;
      m.goe_n[i] = 1'b0;
      case (f)
        GPF_CLK:  m.gout[i] = tmr_r.clk_o;
        GPF_BUF:  m.gout[i] = ~adc_busy;
        GPF_POR:  m.gout[i] = tmr_r.por_cnt != 16'(POR_CYCLES);
        GPF_WAKE: m.gout[i] = spi_r.status[ST_WAKE_BIT];
        GPF_LOW:  m.gout[i] = spi_r.status[ST_LOW_BIT];
        default: begin
          m.gout[i]  = 1'b0;
          m.goe_n[i] = 1'b1;
        end
      endcase
    end
    if (shd) begin
      m = TMR_RST;
    end
    tmr_nxt = m;
  end

  // State registers; shutdown is folded into the next values
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      spi_r <= SPI_RST;
      adc_r <= ADC_RST;
      tmr_r <= TMR_RST;
    end else begin
      spi_r <= spi_nxt;
      adc_r <= adc_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  assign lnk.sdo       = spi_r.sdo;
  assign lnk.sdo_oe_n  = spi_r.sdo_oe_n;
  assign lnk.irq_out_n = spi_r.irq_n;
  assign sar_trial     = adc_r.trial;
  assign sar_chan      = adc_r.ch;
  assign gpio_out      = tmr_r.gout;
  assign gpio_oe_n     = tmr_r.goe_n;
endmodule
`default_nettype wire

// ---- verilog/sma_host.sv ----
// Host end: frames byte transfers on the serial link and drives shutdown.
// Assumes the device answers in the same frame, MSB first.
`timescale 1ns/1ps
`default_nettype none
module sma_host
  import sma_pkg::*;
#(
  parameter int HALF_CYCLES = HOST_HALF_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  sma_link_if.host         lnk,
  input  wire logic        start,
  input  wire logic [1:0]  tx_len,
  input  wire logic [23:0] tx_data,
  input  wire logic [2:0]  rx_len,
  input  wire logic        shutdown_req,
  output wire logic        busy,
  output wire logic        done,
  output wire logic [55:0] rx_data,
  output wire logic        irq_pending
);
  typedef enum logic [1:0] {SMA_H_IDLE, SMA_H_LEAD, SMA_H_SHIFT, SMA_H_TRAIL} sma_hst_t;

  typedef struct packed {
    sma_hst_t    st;
    logic [7:0]  half;
    logic [6:0]  bits;
    logic [6:0]  nbits;
    logic [23:0] txs;
    logic [55:0] rxs;
    logic        sclk;
    logic        sel_n;
    logic        sdi;
    logic        shut;
    logic        busy;
    logic        done;
    logic        irq;
  } sma_host_t;

  localparam sma_host_t HOST_RST = '{st: SMA_H_IDLE, sel_n: 1'b1, default: '0};

  sma_host_t   host_r;
  sma_host_t   host_nxt;
  logic [1:0]  sdo_q;
  logic [1:0]  irq_q;
  logic        half_end;

  // Link inputs come from another domain
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sdo_q <= '0;
      irq_q <= '1;
    end else begin
      sdo_q <= {sdo_q[0], lnk.sdo};
      irq_q <= {irq_q[0], lnk.irq_out_n};
    end
  end

  assign half_end = host_r.half == 8'(HALF_CYCLES - 1);

  // Frame sequencer; half period long enough to cover both synchronisers
  always_comb begin
    sma_host_t h;
    h = host_r;
    h.done = 1'b0;
    h.shut = shutdown_req;
    h.irq  = ~irq_q[1];
    h.half = half_end ? 8'h00 : host_r.half + 8'h01;
    unique case (host_r.st)
      SMA_H_IDLE: begin
        h.half = 8'h00;
        if (start && !shutdown_req) begin
          h.st    = SMA_H_LEAD;
          h.sel_n = 1'b0;
          h.txs   = tx_data;
          h.sdi   = tx_data[23];
          h.bits  = '0;
          h.nbits = (7'(tx_len) + 7'(rx_len)) * 7'(BYTE_W);
          h.busy  = 1'b1;
        end
      end
      SMA_H_LEAD: begin
        if (half_end) begin
          h.st = SMA_H_SHIFT;
        end
      end
      SMA_H_SHIFT: begin
        if (half_end) begin
          h.sclk = ~host_r.sclk;
          if (!host_r.sclk) begin
            h.rxs = {host_r.rxs[54:0], sdo_q[1]};
          end else begin
            h.bits = host_r.bits + 7'h01;
            h.txs  = {host_r.txs[22:0], 1'b0};
            h.sdi  = host_r.txs[22];
            if (host_r.bits + 7'h01 == host_r.nbits) begin
              h.st = SMA_H_TRAIL;
            end
          end
        end
      end
      // Select rises a half period before done so the next frame keeps a gap
      SMA_H_TRAIL: begin
        if (half_end) begin
          if (!host_r.sel_n) begin
            h.sel_n = 1'b1;
            h.sdi   = 1'b0;
          end else begin
            h.st   = SMA_H_IDLE;
            h.busy = 1'b0;
            h.done = 1'b1;
          end
        end
      end
    endcase
    host_nxt = h;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      host_r <= HOST_RST;
    end else begin
      host_r <= host_nxt;
    end
  end

  assign lnk.sclk            = host_r.sclk;
  assign lnk.serial_select_n = host_r.sel_n;
  assign lnk.sdi             = host_r.sdi;
  assign lnk.shutdown_in     = host_r.shut;
  assign busy                = host_r.busy;
  assign done                = host_r.done;
  assign rx_data             = host_r.rxs;
  assign irq_pending         = host_r.irq;
endmodule
`default_nettype wire

// ---- dv/sma_link_asserts.sv ----
// Checker for the serial link, interrupt and shutdown wires between both ends.
// Assumes the host half period of 8 clk_sys and a 2FF sync in the device.
`timescale 1ns/1ps
`default_nettype none
module sma_link_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic irq_out_n,
  input wire logic shutdown_in
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Device side: output drive on select, data hold, interrupt latch and shutdown
  AST_DESEL_QUIET: assert property (serial_select_n [*6] |-> sdo_oe_n && !sdo)
    else $error("data out driven while not selected");
  AST_OE_ON_SELECT: assert property ($fell(serial_select_n) && !shutdown_in |-> ##[2:6] !sdo_oe_n)
    else $error("data out not enabled after select");
  AST_SDO_HOLD: assert property ($rose(sclk) |-> $stable(sdo) [*4])
    else $error("data out moved near rising clock");
  AST_IRQ_LATCH: assert property ((serial_select_n && !shutdown_in) [*6] ##0 !irq_out_n |=> !irq_out_n)
    else $error("interrupt released without status read");
  AST_SHDN_CLEAR: assert property (shutdown_in [*5] |-> irq_out_n && sdo_oe_n)
    else $error("outputs active during shutdown");
  // Host side: framing and clock shape
  AST_SDI_HOLD: assert property (sclk && $past(sclk) |-> $stable(sdi))
    else $error("data in moved while clock high");
  AST_SCLK_IN_FRAME: assert property ($changed(sclk) |-> !serial_select_n)
    else $error("clock toggled outside frame");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("clock high phase not 8 cycles");
  AST_SEL_GAP: assert property ($rose(serial_select_n) |-> serial_select_n [*3])
    else $error("frame gap too short");

  // Main scenarios reached
  COV_FRAME: cover property ($fell(serial_select_n));
  COV_IRQ: cover property ($fell(irq_out_n));
  COV_SHDN: cover property ($rose(shutdown_in));
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Bench joining host and device ends by one link; one task per scenario.
// Assumes shortened converter and wake tick counts, ideal comparator model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sma_pkg::*;
  localparam logic [10:0] V_TEMP = 11'h2a5;
  localparam logic [10:0] V_SUP  = 11'h5b0; // Reads as 2559 mV
  localparam logic [10:0] V_GPIO = 11'h123;
  logic        clk_sys, arst_n, start, shutdown_req, busy, done, irq_pending, sar_cmp;
  logic [1:0]  tx_len, sar_chan, gpio_out, gpio_oe_n;
  logic [2:0]  rx_len;
  logic [23:0] tx_data;
  logic [55:0] rx_data;
  logic [10:0] sar_trial, vin;
  int          err_total, checks_done;

  sma_link_if lnk();
  sma_dev #(.CONV_CYCLES(44), .WAKE_TICK_CYCLES(50)) i_sma_dev (
    .clk_sys(clk_sys), .arst_n(arst_n), .lnk(lnk), .sar_trial(sar_trial),
    .sar_chan(sar_chan), .sar_cmp(sar_cmp), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
  sma_host i_sma_host (
    .clk_sys(clk_sys), .arst_n(arst_n), .lnk(lnk), .start(start), .tx_len(tx_len),
    .tx_data(tx_data), .rx_len(rx_len), .shutdown_req(shutdown_req), .busy(busy),
    .done(done), .rx_data(rx_data), .irq_pending(irq_pending));
  sma_link_asserts i_sma_link_asserts (
    .clk_sys(clk_sys), .arst_n(arst_n), .sclk(lnk.sclk), .serial_select_n(lnk.serial_select_n),
    .sdi(lnk.sdi), .sdo(lnk.sdo), .sdo_oe_n(lnk.sdo_oe_n), .irq_out_n(lnk.irq_out_n),
    .shutdown_in(lnk.shutdown_in));

  // Ideal comparator; inputs held constant so each result is exact
  always_comb begin
    vin = (sar_chan == CH_TEMP) ? V_TEMP : ((sar_chan == CH_SUPPLY) ? V_SUP : V_GPIO);
    sar_cmp = (vin >= sar_trial);
  end

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One host frame; done is sampled mid-cycle to avoid the edge race
  task automatic xfer(input logic [1:0] n, input logic [23:0] d, input logic [2:0] r);
    int k;
    @(posedge clk_sys);
    start <= 1'b1;
    tx_len <= n;
    tx_data <= d;
    rx_len <= r;
    @(posedge clk_sys);
    start <= 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge clk_sys);
    if (k == 3000) begin
      err_total++;
      $display("[ERR] %0t frame hung", $time);
      finish_test();
    end
  endtask

  task automatic setp(input logic [7:0] idx, input logic [7:0] val);
    xfer(2'd3, {CMD_SET_PROP, idx, val}, 3'd0);
  endtask

  task automatic status();
    xfer(2'd1, {CMD_GET_STATUS, 16'h0}, 3'd1);
  endtask

  task automatic t_reset();
    chk({lnk.irq_out_n, lnk.sdo_oe_n, gpio_oe_n, busy}, 5'b11110, "reset levels");
  endtask

  // Temp and pin selected, supply left out; poll until ready
  task automatic t_convert();
    xfer(2'd2, {CMD_READ_CONVERTER, 8'h05, 8'h00}, 3'd0);
    for (int k = 0; k < 20; k++) begin
      xfer(2'd1, {CMD_READ_REPLY, 16'h0}, 3'd7);
      if (rx_data[55:48] === REPLY_READY) break;
    end
    chk(rx_data[55:48], REPLY_READY, "conv ready");
    chk(rx_data[47:32], {5'h0, V_TEMP}, "temp code");
    chk(rx_data[31:16], 16'h0, "supply unselected");
    chk(rx_data[15:0], {5'h0, V_GPIO}, "pin code");
    xfer(2'd1, {8'h99, 16'h0}, 3'd1);
    chk(rx_data[7:0], REPLY_BUSY, "unknown command");
  endtask

  // Every pin function, then the clock output rate
  task automatic t_gpio();
    int e;
    logic p;
    for (int f = 0; f < 6; f++) begin
      setp(PROP_GPIO1, 8'(f));
      wait_cyc(4);
      chk(gpio_oe_n[1], (f == 0), "pin drive");
      // Idle converter reads high; POR done and both flags clear read low
      if (f != 1) chk(gpio_out[1], (f == 2), "pin level");
    end
    setp(PROP_GPIO1, {5'h0, GPF_CLK});
    e = 0;
    repeat (32) begin
      p = gpio_out[1];
      @(negedge clk_sys);
      if (gpio_out[1] !== p) e++;
    end
    chk(16'(e), 16'd8, "clock out edges");
  endtask

  // Threshold just below, then just above the supply reading
  task automatic t_detect();
    setp(PROP_IRQ_EN, 8'h02);
    setp(PROP_SUPPLY_THR, 8'd21);
    setp(PROP_GPIO0, {5'h0, GPF_LOW});
    setp(PROP_WAKE_PERIOD, 8'h01);
    setp(PROP_WAKE_CFG, 8'h03);
    wait_cyc(800);
    chk(lnk.irq_out_n, 1'b1, "no irq at 2550");
    status();
    chk(rx_data[1:0], 2'b01, "wake only");
    setp(PROP_SUPPLY_THR, 8'd22);
    wait_cyc(800);
    chk({lnk.irq_out_n, irq_pending, gpio_out[0], gpio_oe_n[0]}, 4'b0110, "low at 2600");
    setp(PROP_WAKE_CFG, 8'h02);
    wait_cyc(800);
    chk(lnk.irq_out_n, 1'b0, "flag latched");
    status();
    chk(rx_data[1], 1'b1, "low flag read");
    wait_cyc(800);
    status();
    chk({lnk.irq_out_n, rx_data[1]}, 2'b10, "detector idle");
  endtask

  // Shutdown clears a pending interrupt and all settings
  task automatic t_shutdown();
    setp(PROP_IRQ_EN, 8'h01);
    setp(PROP_WAKE_CFG, 8'h03);
    wait_cyc(800);
    chk(lnk.irq_out_n, 1'b0, "irq before off");
    shutdown_req <= 1'b1;
    wait_cyc(20);
    chk({lnk.irq_out_n, lnk.sdo_oe_n, gpio_oe_n}, 4'hf, "off state");
    shutdown_req <= 1'b0;
    wait_cyc(800);
    chk(lnk.irq_out_n, 1'b1, "settings lost");
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    start = 1'b0;
    shutdown_req = 1'b0;
    tx_len = 2'h0;
    tx_data = 24'h0;
    rx_len = 3'h0;
    err_total = 0;
    checks_done = 0;
    wait_cyc(10);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    t_reset();
    wait_cyc(30); // Let power-on count finish
    t_convert();
    t_gpio();
    t_detect();
    t_shutdown();
    finish_test();
  end
endmodule
`default_nettype wire
